/* File: verilog/supervisor_pkg.sv */
// shared constants and carrier types for the supply supervisor with watchdog
package supervisor_pkg;

  // clock rate in kHz and timebase tick period in us
  localparam int unsigned CLK_KHZ      = 100000;
  localparam int unsigned TICK_US      = 100;
  localparam int unsigned TICK_CYCLES  = (CLK_KHZ / 1000) * TICK_US;

  // release delay, ms
  localparam int unsigned DELAY_SHORT_MS = 25;
  localparam int unsigned DELAY_LONG_MS  = 200;
  // watchdog timeout, ms
  localparam int unsigned WDOG_SHORT_MS  = 200;
  localparam int unsigned WDOG_LONG_MS   = 1600;

  localparam int unsigned TICKS_PER_MS   = 1000 / TICK_US;
  localparam int unsigned DELAY_TICKS    = DELAY_LONG_MS * TICKS_PER_MS;
  localparam int unsigned WDOG_TICKS     = WDOG_LONG_MS * TICKS_PER_MS;
  localparam int unsigned DELAY_SHORT_TICKS = DELAY_SHORT_MS * TICKS_PER_MS;
  localparam int unsigned WDOG_SHORT_TICKS  = WDOG_SHORT_MS * TICKS_PER_MS;

  localparam int unsigned CNT_W = 16;

  // reset-state values of the synchronised inputs
  localparam logic SYNC_RESET_VAL   = 1'b0;
  localparam logic MANUAL_RESET_VAL = 1'b0;

  typedef enum logic [1:0] {
    ST_HOLD    = 2'b00,
    ST_DELAY   = 2'b01,
    ST_RUN     = 2'b10
  } sup_state_t;

  typedef struct packed {
    logic reset_n;
    logic reset_hi;
  } reset_pair_t;

  typedef struct packed {
    logic supply_good;
    logic manual_reset_n;
    logic kick;
  } sync_in_t;

endpackage

/* File: verilog/sync_bit.sv */
// two-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module sync_bit #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // data
  input  wire logic d,
  output var  logic q
);

  logic meta;
  logic next_meta;
  logic next_q;

  always_comb
  begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= RESET_VAL;
      q    <= RESET_VAL;
    end
    else
    begin
      meta <= next_meta;
      q    <= next_q;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/supply_supervisor_watchdog_reset.sv */
// reset supervisor: supply-good, manual reset and watchdog feed one stretched reset
`timescale 1ns/1ps
`default_nettype none
// Contract
// - reset is asserted from the moment the logic is powered, i.e. throughout and right after rst_n.
// - the active-low reset output stays low while supply-good reports the supply below the trip level.
// - the active-high reset output is high in the same cases, always the complement of the active-low one.
// - after its cause clears, reset stays asserted for the release delay, 25 ms short variant, 200 ms otherwise.
// - the release delay starts only once supply-good reports the supply above trip level plus hysteresis.
// - a supply drop reasserts reset at once and abandons any delay count in progress.
// - manual reset forces reset regardless of the supply state and the watchdog.
// - a low manual reset input makes every reset output active; the far party drives it high otherwise.
// - watchdog timeout is 200 ms on the short variant and 1.6 s on the long one.
// - any edge on the kick input restarts the watchdog; the far party must kick within every timeout.
// - on watchdog expiry reset is asserted for the release delay and the watchdog is reinitialised.
// - kicks while reset is asserted never lock reset on; release proceeds normally.
module supply_supervisor_watchdog_reset #(
  parameter int unsigned TICK_CYCLES = supervisor_pkg::TICK_CYCLES,
  parameter int unsigned DELAY_TICKS = supervisor_pkg::DELAY_TICKS,
  parameter int unsigned WDOG_TICKS  = supervisor_pkg::WDOG_TICKS
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // supervised inputs
  input  wire logic supply_good,
  input  wire logic manual_reset_in_n,
  input  wire logic watchdog_kick_in,
  // reset outputs
  output var  logic sys_reset_n,
  output var  logic sys_reset
);

  localparam int W = supervisor_pkg::CNT_W;

  supervisor_pkg::sync_in_t   sin;
  supervisor_pkg::sup_state_t state;
  supervisor_pkg::sup_state_t next_state;
  supervisor_pkg::reset_pair_t rout;
  supervisor_pkg::reset_pair_t next_rout;
  logic [W-1:0] tick_cnt;
  logic [W-1:0] next_tick_cnt;
  logic         tick;
  logic         next_tick;
  logic [W-1:0] delay_cnt;
  logic [W-1:0] next_delay_cnt;
  logic [W-1:0] wdog_cnt;
  logic [W-1:0] next_wdog_cnt;
  logic         kick_prev;
  logic         next_kick_prev;
  logic         kick_edge;
  logic         cause;

  sync_bit #(.RESET_VAL(supervisor_pkg::SYNC_RESET_VAL)) u_sync_supply (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (supply_good),
    .q     (sin.supply_good)
  );
  sync_bit #(.RESET_VAL(supervisor_pkg::MANUAL_RESET_VAL)) u_sync_manual (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (manual_reset_in_n),
    .q     (sin.manual_reset_n)
  );
  sync_bit #(.RESET_VAL(supervisor_pkg::SYNC_RESET_VAL)) u_sync_kick (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (watchdog_kick_in),
    .q     (sin.kick)
  );

  // either polarity of kick edge counts
  assign kick_edge = sin.kick ^ kick_prev;
  // supply-good already carries hysteresis, so its rise is the upper trip
  assign cause = !sin.supply_good || !sin.manual_reset_n;

  always_comb
  begin
    next_tick_cnt  = tick_cnt + W'(1);
    next_tick      = 1'b0;
    if (tick_cnt >= W'(TICK_CYCLES - 1))
    begin
      next_tick_cnt = '0;
      next_tick     = 1'b1;
    end
    next_kick_prev = sin.kick;
    next_state     = state;
    next_delay_cnt = delay_cnt;
    next_wdog_cnt  = wdog_cnt;
    case (state)
      supervisor_pkg::ST_HOLD:
      begin
        next_delay_cnt = '0;
        next_wdog_cnt  = '0;
        if (!cause)
          next_state = supervisor_pkg::ST_DELAY;
      end
      supervisor_pkg::ST_DELAY:
      begin
        // kicks here are ignored, so they cannot pin reset on
        next_wdog_cnt = '0;
        if (cause)
          next_state = supervisor_pkg::ST_HOLD;
        else if (tick)
        begin
          if (delay_cnt >= W'(DELAY_TICKS - 1))
            next_state = supervisor_pkg::ST_RUN;
          else
            next_delay_cnt = delay_cnt + W'(1);
        end
      end
      supervisor_pkg::ST_RUN:
      begin
        if (cause)
          next_state = supervisor_pkg::ST_HOLD;
        else if (kick_edge)
          next_wdog_cnt = '0;
        else if (tick)
        begin
          if (wdog_cnt >= W'(WDOG_TICKS - 1))
          begin
            next_state     = supervisor_pkg::ST_DELAY;
            next_delay_cnt = '0;
            next_wdog_cnt  = '0;
          end
          else
            next_wdog_cnt = wdog_cnt + W'(1);
        end
      end
      default:
        next_state = supervisor_pkg::ST_HOLD;
    endcase
    // reset is asserted in every state but run, and asserted on the same edge that a cause takes state out of run
    next_rout.reset_n  = (next_state == supervisor_pkg::ST_RUN);
    next_rout.reset_hi = !next_rout.reset_n;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt  <= '0;
      tick      <= 1'b0;
      kick_prev <= supervisor_pkg::SYNC_RESET_VAL;
      state     <= supervisor_pkg::ST_HOLD;
      delay_cnt <= '0;
      wdog_cnt  <= '0;
      rout      <= '{reset_n: 1'b0, reset_hi: 1'b1};
    end
    else
    begin
      tick_cnt  <= next_tick_cnt;
      tick      <= next_tick;
      kick_prev <= next_kick_prev;
      state     <= next_state;
      delay_cnt <= next_delay_cnt;
      wdog_cnt  <= next_wdog_cnt;
      rout      <= next_rout;
    end
  end

  assign sys_reset_n = rout.reset_n;
  assign sys_reset   = rout.reset_hi;

  // checks
  property p_complement;
    @(posedge mclk) disable iff (!rst_n) sys_reset == !sys_reset_n;
  endproperty
  a_complement: assert property (p_complement) else $error("reset outputs not complementary");

  property p_supply_low;
    @(posedge mclk) disable iff (!rst_n) !sin.supply_good |=> !sys_reset_n;
  endproperty
  a_supply_low: assert property (p_supply_low) else $error("reset released with supply low");

  property p_manual_low;
    @(posedge mclk) disable iff (!rst_n) !sin.manual_reset_n |=> !sys_reset_n && sys_reset;
  endproperty
  a_manual_low: assert property (p_manual_low) else $error("manual reset not honoured");

  property p_drop_abandons;
    @(posedge mclk) disable iff (!rst_n)
      (state == supervisor_pkg::ST_DELAY && cause) |=> state == supervisor_pkg::ST_HOLD;
  endproperty
  a_drop_abandons: assert property (p_drop_abandons) else $error("delay not abandoned");

  property p_override;
    @(posedge mclk) disable iff (!rst_n)
      (state == supervisor_pkg::ST_RUN && !sin.manual_reset_n) |=> state == supervisor_pkg::ST_HOLD;
  endproperty
  a_override: assert property (p_override) else $error("manual reset did not override");

  property p_start_on_good;
    @(posedge mclk) disable iff (!rst_n)
      (state == supervisor_pkg::ST_HOLD && !cause) |=> state == supervisor_pkg::ST_DELAY && delay_cnt == '0;
  endproperty
  a_start_on_good: assert property (p_start_on_good) else $error("delay not started");

  property p_release_only_after_delay;
    @(posedge mclk) disable iff (!rst_n)
      $rose(sys_reset_n) |-> $past(delay_cnt) == W'(DELAY_TICKS - 1);
  endproperty
  a_release_only_after_delay: assert property (p_release_only_after_delay)
    else $error("reset released early");

  property p_kick_restarts;
    @(posedge mclk) disable iff (!rst_n)
      (state == supervisor_pkg::ST_RUN && !cause && kick_edge) |=> wdog_cnt == '0;
  endproperty
  a_kick_restarts: assert property (p_kick_restarts) else $error("kick did not restart watchdog");

  property p_expiry;
    @(posedge mclk) disable iff (!rst_n)
      (state == supervisor_pkg::ST_RUN && !cause && !kick_edge && tick && wdog_cnt == W'(WDOG_TICKS - 1))
      |=> state == supervisor_pkg::ST_DELAY && wdog_cnt == '0 ##1 !sys_reset_n;
  endproperty
  a_expiry: assert property (p_expiry) else $error("watchdog expiry mishandled");

  c_release:  cover property (@(posedge mclk) disable iff (!rst_n) $rose(sys_reset_n));
  c_expiry:   cover property (@(posedge mclk) disable iff (!rst_n)
    state == supervisor_pkg::ST_RUN ##1 state == supervisor_pkg::ST_DELAY);
  c_manual_abort: cover property (@(posedge mclk) disable iff (!rst_n)
    state == supervisor_pkg::ST_DELAY && !sin.manual_reset_n);
  c_kick_in_delay: cover property (@(posedge mclk) disable iff (!rst_n)
    state == supervisor_pkg::ST_DELAY && kick_edge);

endmodule
`default_nettype wire

/* File: bench/supervised_cpu_model.sv */
// supervised processor model: manual reset request and watchdog kicks
`timescale 1ns/1ps
`default_nettype none
module supervised_cpu_model #(
  parameter int unsigned KICK_GAP = 4
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // commands from the bench
  input  wire logic kick_on,
  input  wire logic kick_in_reset,
  input  wire logic manual_req,
  // supervisor side
  input  wire logic sys_reset_n,
  output var  logic manual_reset_in_n,
  output var  logic watchdog_kick_in
);
  int unsigned gap;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap <= 0;
      watchdog_kick_in <= 1'b0;
      manual_reset_in_n <= 1'b1;
    end
    else
    begin
      manual_reset_in_n <= ~manual_req;
      // a cpu held in reset cannot kick; kick_in_reset models glue that still toggles
      if (kick_on && (sys_reset_n || kick_in_reset))
      begin
        gap <= (gap == KICK_GAP - 1) ? 0 : gap + 1;
        if (gap == KICK_GAP - 1)
          watchdog_kick_in <= ~watchdog_kick_in;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/supply_supervisor_watchdog_reset_test.sv */
// self-checking bench for the supply supervisor with watchdog
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_reset_test;
  // short counts keep the run brief
  localparam int TC  = 2;
  localparam int DT  = 5;
  localparam int WT  = 8;
  localparam int DLY = DT * TC;
  localparam int WDG = WT * TC;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_good = 1'b1;
  logic kick_on = 1'b1;
  logic kick_in_reset = 1'b0;
  logic manual_req = 1'b0;
  wire logic manual_n;
  wire logic kick;
  wire logic sys_reset_n;
  wire logic sys_reset;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;

  supply_supervisor_watchdog_reset #(.TICK_CYCLES(TC), .DELAY_TICKS(DT), .WDOG_TICKS(WT)) uut (
    .mclk(mclk), .rst_n(rst_n), .supply_good(supply_good), .manual_reset_in_n(manual_n),
    .watchdog_kick_in(kick), .sys_reset_n(sys_reset_n), .sys_reset(sys_reset));
  supervised_cpu_model cpu (
    .mclk(mclk), .rst_n(rst_n), .kick_on(kick_on), .kick_in_reset(kick_in_reset), .manual_req(manual_req),
    .sys_reset_n(sys_reset_n), .manual_reset_in_n(manual_n), .watchdog_kick_in(kick));

  initial
  begin
    forever #5 mclk = ~mclk;
  end

  task automatic end_of_test();
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // generous ceiling: the whole sequence needs a few hundred cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic check_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_count(input string what, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi)
    begin
      bad_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // edges until the active-low output reaches lvl; outputs settle 1 ns after the edge
  task automatic wait_out(input logic lvl, input int lim, output int n);
    n = 0;
    #1;
    while (sys_reset_n !== lvl && n < lim)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    check_bit("sys_reset", ~lvl, sys_reset);
  endtask

  task automatic hold_out(input logic lvl, input int n);
    int off;
    off = 0;
    repeat (n)
    begin
      @(posedge mclk);
      #1;
      if (sys_reset_n !== lvl)
        off++;
    end
    check_count("cycles off level", 0, 0, off);
  endtask

  task automatic supply_drop();
    int n;
    @(posedge mclk);
    supply_good <= 1'b0;
    wait_out(1'b0, 8, n);
    check_count("supply assert delay", 1, 4, n);
    hold_out(1'b0, 2 * DLY);
    @(posedge mclk);
    supply_good <= 1'b1;
    hold_out(1'b0, DLY / 2);
    // a short dip mid-count must restart the whole delay
    @(posedge mclk);
    supply_good <= 1'b0;
    hold_out(1'b0, 4);
    @(posedge mclk);
    supply_good <= 1'b1;
    wait_out(1'b1, DLY + 20, n);
    check_count("restarted delay", DLY, DLY + TC + 6, n);
  endtask

  task automatic manual_reset();
    int n;
    @(posedge mclk);
    manual_req <= 1'b1;
    kick_on <= 1'b0;
    wait_out(1'b0, 8, n);
    check_count("manual assert delay", 1, 5, n);
    hold_out(1'b0, 2 * WDG);
    @(posedge mclk);
    manual_req <= 1'b0;
    kick_on <= 1'b1;
    wait_out(1'b1, DLY + 20, n);
    check_count("manual release delay", DLY, DLY + TC + 7, n);
  endtask

  task automatic watchdog();
    int n;
    hold_out(1'b1, 3 * WDG);
    @(posedge mclk);
    kick_on <= 1'b0;
    wait_out(1'b0, WDG + 20, n);
    check_count("watchdog timeout", WDG - 5, WDG + TC + 6, n);
    @(posedge mclk);
    kick_on <= 1'b1;
    kick_in_reset <= 1'b1;
    wait_out(1'b1, DLY + 20, n);
    check_count("expiry reset length", DLY - 2, DLY + TC + 6, n);
    hold_out(1'b1, 2 * WDG);
    @(posedge mclk);
    kick_in_reset <= 1'b0;
  endtask

  // a second manual request lands while the release delay is counting
  task automatic manual_abort();
    int n;
    @(posedge mclk);
    manual_req <= 1'b1;
    wait_out(1'b0, 8, n);
    check_count("abort assert delay", 1, 5, n);
    @(posedge mclk);
    manual_req <= 1'b0;
    hold_out(1'b0, DLY / 2);
    @(posedge mclk);
    manual_req <= 1'b1;
    hold_out(1'b0, 4);
    @(posedge mclk);
    manual_req <= 1'b0;
    wait_out(1'b1, DLY + 20, n);
    check_count("abort release delay", DLY, DLY + TC + 7, n);
  endtask

  initial
  begin
    int n;
    repeat (7) @(posedge mclk);
    #1;
    check_bit("sys_reset_n", 1'b0, sys_reset_n);
    check_bit("sys_reset", 1'b1, sys_reset);
    @(posedge mclk);
    rst_n <= 1'b1;
    wait_out(1'b1, DLY + 20, n);
    check_count("power-up delay", DLY, DLY + TC + 6, n);
    supply_drop();
    manual_reset();
    watchdog();
    manual_abort();
    end_of_test();
  end
endmodule
`default_nettype wire
